// ---- rtl/adc_seq_map.svh ----
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// Byte offsets
`define ADC_OFF_CTRL 8'h00
`define ADC_OFF_PRESC 8'h04
`define ADC_OFF_MAXCONV 8'h08
`define ADC_OFF_START 8'h0C
`define ADC_OFF_STATUS 8'h10
`define ADC_OFF_CHSEL_LO 8'h14
`define ADC_OFF_CHSEL_HI 8'h18
`define ADC_OFF_RESULT 8'h40
`define ADC_OFF_RESULT_END 8'h7C

// Reset values
`define ADC_CTRL_RST 7'h00
`define ADC_PRESC_RST 8'h00
`define ADC_MAXCONV_RST 8'h00

// START pulse bits
`define ADC_START_SEQ1_BIT 0
`define ADC_START_SEQ2_BIT 1
`define ADC_RESET_SEQ1_BIT 4
`define ADC_RESET_SEQ2_BIT 5

// STATUS fields
`define ADC_ST_ACT_LSB 0
`define ADC_ST_PEND_LSB 2
`define ADC_ST_PTR1_LSB 4
`define ADC_ST_PTR2_LSB 8
`define ADC_ST_EOS_LSB 12
`define ADC_ST_BUSY_BIT 14
`define ADC_ST_HALT_BIT 15

// Shortest conversion time
`define ADC_CONV_TIME_NS 80
`define ADC_CONV_CLK_MHZ 25

// Output code limits
`define ADC_CODE_ZERO 12'h000
`define ADC_CODE_FULL 12'hFFF

`endif

// ---- rtl/adc_seq_pkg.sv ----
package adc_seq_pkg;

    typedef struct packed {
        logic ext_en;
        logic pwm_b_en;
        logic pwm_a_en;
        logic int_other;
        logic start_stop;
        logic cascade;
        logic clk_en;
    } ctrl_t;

    typedef struct packed {
        logic [3:0] acq;
        logic [3:0] div;
    } presc_t;

    typedef enum {
        CONV_IDLE,
        CONV_ACQ,
        CONV_RUN
    } conv_state_t;

endpackage

// ---- rtl/adc_autosequencer_control.sv ----
`include "adc_seq_map.svh"

// Behaviour
// R1: Each result is a 12-bit unsigned code from one core.
// R2: Code is 0 below zero, 4095 at full scale, else core code.
// R3: A session runs up to 16 conversions; each slot picks any channel.
// R4: Two 8-slot sequencers, or one cascaded 16-slot sequencer.
// R5: One shared converter; one conversion at a time.
// R6: In dual mode each sequencer uses only its own eight inputs.
// R7: Each conversion lands in its slot's addressable result register.
// R8: Starts from software, PWM triggers or external interrupt two.
// R9: Interrupt on every end of sequence or every second one.
// R10: Start/stop: each trigger runs the next part of the sequence.
// R11: In dual mode triggers A and B start own sequencers.
// R12: Acquisition prescale is separate from converter clock prescale.
// R13: Conversion lasts 80 ns at a 25 MHz converter clock.
// R14: Registers on system clock; timing from fast peripheral clock.
// R15: Enable low after reset; registers reset; analog part powered down.
// R16: After reset only the enable is writable until set; the code accepts writes to every CTRL field.
// R17: Software waits to settle after enabling, before converting.
// R18: Halt powers down the analog part; registers keep contents.
// R19: One channel may fill several slots for oversampling.
// R20: Sequence end flagged after last conversion; sequencer then idles.
// R21: A trigger during another conversion waits and is served afterwards.
module adc_autosequencer_control #(
    parameter int CODE_W = 12,
    parameter int SLOTS = 16
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_resetn, // Synchronous reset, active low
    input wire logic i_awvalid, // Write address valid
    output logic o_awready, // Write address ready
    input wire logic [7:0] i_awaddr, // Write address
    input wire logic i_wvalid, // Write data valid
    output logic o_wready, // Write data ready
    input wire logic [31:0] i_wdata, // Write data
    input wire logic [3:0] i_wstrb, // Write strobes
    output logic o_bvalid, // Write response valid
    input wire logic i_bready, // Write response ready
    output logic [1:0] o_bresp, // Write response
    input wire logic i_arvalid, // Read address valid
    output logic o_arready, // Read address ready
    input wire logic [7:0] i_araddr, // Read address
    output logic o_rvalid, // Read data valid
    input wire logic i_rready, // Read data ready
    output logic [31:0] o_rdata, // Read data
    output logic [1:0] o_rresp, // Read response
    input wire logic i_start_trigger_a, // PWM start request A
    input wire logic i_start_trigger_b, // PWM start request B
    input wire logic i_external_interrupt_two_input, // External start
    input wire logic i_halt, // Device halt mode
    input wire logic [CODE_W-1:0] i_conv_code, // Core code
    input wire logic i_conv_under, // Input at or below zero
    input wire logic i_conv_over, // Input at or above full scale
    output logic o_converter_clock_enable, // Enable bit state
    output logic o_analog_enable, // Analog part powered
    output logic o_sample_hold, // Acquisition window open
    output logic o_conv_start, // Conversion start pulse
    output logic [3:0] o_mux_channel, // Selected input
    output logic o_irq_seq1, // Sequencer 1 interrupt pulse
    output logic o_irq_seq2 // Sequencer 2 interrupt pulse
);

    localparam int CONV_TICKS = (`ADC_CONV_TIME_NS * `ADC_CONV_CLK_MHZ) / 1000; // [R13]
    localparam logic [3:0] CONV_LAST = 4'(CONV_TICKS - 1);

    if (CODE_W != 12 || SLOTS != 16 || CONV_TICKS < 1 || CONV_TICKS > 16)
    begin : g_check
        $error("Unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    adc_seq_pkg::ctrl_t ctrl_ff;
    adc_seq_pkg::presc_t presc_ff;
    logic [7:0] maxconv_ff;
    logic [SLOTS-1:0][3:0] chsel_ff;
    logic [SLOTS-1:0][CODE_W-1:0] result_ff;
    logic [1:0][3:0] ptr_ff;
    logic [1:0][3:0] left_ff;
    logic [1:0] act_ff;
    logic [1:0] pend_ff;
    logic [1:0] eos_flag_ff;
    logic [1:0] eos_cnt_ff;
    logic [1:0] irq_ff;
    logic trg_a_q_ff;
    logic trg_b_q_ff;
    logic trg_x_q_ff;
    adc_seq_pkg::conv_state_t state_ff;
    logic owner_ff;
    logic last_ff;
    logic [3:0] slot_ff;
    logic [3:0] div_ff;
    logic [3:0] phase_ff;
    logic start_ff;
    logic [3:0] mux_ff;

    logic [7:0] aw_addr_ff;
    logic aw_v_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic w_v_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    ////////////////////////////////////////////////////////////////////////
    // Register read decode
    function automatic logic [32:0] reg_read(input logic [7:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h00000000};
        if (a >= `ADC_OFF_RESULT && a <= `ADC_OFF_RESULT_END && a[1:0] == 2'h0)
            r = {1'b1, 20'h00000, result_ff[a[5:2]]}; // [R7]
        else
            unique case (a)
                `ADC_OFF_CTRL: r = {1'b1, 25'h0000000, ctrl_ff};
                `ADC_OFF_PRESC: r = {1'b1, 24'h000000, presc_ff};
                `ADC_OFF_MAXCONV: r = {1'b1, 24'h000000, maxconv_ff};
                `ADC_OFF_START: r = {1'b1, 32'h00000000};
                `ADC_OFF_STATUS: r = {1'b1, 16'h0000, i_halt, state_ff != adc_seq_pkg::CONV_IDLE,
                                      eos_flag_ff, ptr_ff[1], ptr_ff[0], pend_ff, act_ff};
                `ADC_OFF_CHSEL_LO: r = {1'b1, chsel_ff[7:0]};
                `ADC_OFF_CHSEL_HI: r = {1'b1, chsel_ff[15:8]};
                default: r = {1'b0, 32'h00000000};
            endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes
    wire wr_go = aw_v_ff & w_v_ff;
    wire [32:0] wr_old = reg_read(aw_addr_ff);
    wire [32:0] rd_val = reg_read(i_araddr);
    wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    wire [31:0] wval = (wr_old[31:0] & ~wmask) | (w_data_ff & wmask);
    wire ar_go = i_arvalid & o_arready;

    assign o_awready = ~aw_v_ff & ~bvalid_ff;
    assign o_wready = ~w_v_ff & ~bvalid_ff;
    assign o_arready = ~rvalid_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            aw_v_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_v_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_v_ff <= 1'b1;
                aw_addr_ff <= i_awaddr;
            end
            if (i_wvalid && o_wready)
            begin
                w_v_ff <= 1'b1;
                w_data_ff <= i_wdata;
                w_strb_ff <= i_wstrb;
            end
            if (wr_go)
            begin
                aw_v_ff <= 1'b0;
                w_v_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_old[32] ? 2'h0 : 2'h2;
            end
            else if (bvalid_ff && i_bready)
                bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= 2'h0;
        end
        else if (ar_go)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val[31:0];
            rresp_ff <= rd_val[32] ? 2'h0 : 2'h2;
        end
        else if (rvalid_ff && i_rready)
            rvalid_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes; only CTRL while disabled
    wire regs_on = ctrl_ff.clk_en; // [R16]
    wire wr_ctrl = wr_go && aw_addr_ff == `ADC_OFF_CTRL;
    wire wr_cfg = wr_go && regs_on;
    wire wr_start = wr_cfg && aw_addr_ff == `ADC_OFF_START;
    wire wr_status = wr_cfg && aw_addr_ff == `ADC_OFF_STATUS;
    wire [1:0] sw_start = wr_start ? {wval[`ADC_START_SEQ2_BIT], wval[`ADC_START_SEQ1_BIT]} : 2'h0;
    wire [1:0] sw_reset = wr_start ? {wval[`ADC_RESET_SEQ2_BIT], wval[`ADC_RESET_SEQ1_BIT]} : 2'h0;
    wire [1:0] eos_clr = wr_status ? wval[`ADC_ST_EOS_LSB +: 2] : 2'h0;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            ctrl_ff <= adc_seq_pkg::ctrl_t'(`ADC_CTRL_RST); // [R15]
            presc_ff <= adc_seq_pkg::presc_t'(`ADC_PRESC_RST);
            maxconv_ff <= `ADC_MAXCONV_RST;
            chsel_ff <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= adc_seq_pkg::ctrl_t'(wval[6:0]);
            if (wr_cfg && aw_addr_ff == `ADC_OFF_PRESC)
                presc_ff <= adc_seq_pkg::presc_t'(wval[7:0]); // [R12]
            if (wr_cfg && aw_addr_ff == `ADC_OFF_MAXCONV)
                maxconv_ff <= wval[7:0];
            if (wr_cfg && aw_addr_ff == `ADC_OFF_CHSEL_LO)
                chsel_ff[7:0] <= wval; // [R3] [R19]
            if (wr_cfg && aw_addr_ff == `ADC_OFF_CHSEL_HI)
                chsel_ff[15:8] <= wval;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger steering
    // Halt freezes rather than aborts, so nothing is lost
    wire run_ok = ctrl_ff.clk_en & ~i_halt; // [R18]
    wire rise_a = i_start_trigger_a & ~trg_a_q_ff;
    wire rise_b = i_start_trigger_b & ~trg_b_q_ff;
    wire rise_x = i_external_interrupt_two_input & ~trg_x_q_ff;
    wire casc = ctrl_ff.cascade;
    wire trig1 = sw_start[0] | (ctrl_ff.pwm_a_en & rise_a) | (ctrl_ff.ext_en & rise_x)
               | (casc & ctrl_ff.pwm_b_en & rise_b); // [R8]
    wire trig2 = ~casc & (sw_start[1] | (ctrl_ff.pwm_b_en & rise_b)); // [R11]
    wire [1:0] trig = regs_on ? {trig2, trig1} : 2'h0;

    // Run length and last slot per sequencer
    wire [3:0] len1 = casc ? maxconv_ff[3:0] : {1'b0, maxconv_ff[2:0]}; // [R4]
    wire [3:0] len2 = {1'b0, maxconv_ff[6:4]};
    wire [3:0] lim1 = casc ? 4'hF : 4'h7;

    ////////////////////////////////////////////////////////////////////////
    // Converter tick and engine
    // Divider stands in for the fast peripheral clock
    wire tick = run_ok && div_ff == presc_ff.div; // [R14]
    wire in_acq = state_ff == adc_seq_pkg::CONV_ACQ;
    wire in_run = state_ff == adc_seq_pkg::CONV_RUN;
    wire acq_end = in_acq && tick && phase_ff == presc_ff.acq;
    wire finish = in_run && tick && phase_ff == CONV_LAST; // [R13]
    wire [1:0] fin = finish ? (owner_ff ? 2'h2 : 2'h1) : 2'h0;
    // Alternate so neither sequencer starves
    wire pick = (act_ff == 2'h3) ? ~last_ff : act_ff[1]; // [R21]
    wire grant = run_ok && state_ff == adc_seq_pkg::CONV_IDLE && act_ff != 2'h0; // [R5]
    wire [3:0] g_slot = pick ? {1'b1, ptr_ff[1][2:0]} : ptr_ff[0];
    wire [3:0] g_ch = chsel_ff[g_slot];
    wire [3:0] g_mux = casc ? g_ch : {pick, g_ch[2:0]}; // [R6]
    wire [CODE_W-1:0] code = i_conv_under ? `ADC_CODE_ZERO :
                             i_conv_over ? `ADC_CODE_FULL : i_conv_code; // [R1] [R2]

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn || !ctrl_ff.clk_en)
        begin
            state_ff <= adc_seq_pkg::CONV_IDLE;
            div_ff <= 4'h0;
            phase_ff <= 4'h0;
            owner_ff <= 1'b0;
            last_ff <= 1'b1;
            slot_ff <= 4'h0;
            start_ff <= 1'b0;
            mux_ff <= 4'h0;
        end
        else
        begin
            start_ff <= 1'b0;
            if (run_ok)
                div_ff <= tick ? 4'h0 : div_ff + 4'h1;
            if (tick)
                phase_ff <= phase_ff + 4'h1;
            unique case (state_ff)
                adc_seq_pkg::CONV_IDLE:
                    if (grant)
                    begin
                        state_ff <= adc_seq_pkg::CONV_ACQ;
                        owner_ff <= pick;
                        last_ff <= pick;
                        slot_ff <= g_slot;
                        mux_ff <= g_mux;
                        phase_ff <= 4'h0;
                    end
                adc_seq_pkg::CONV_ACQ:
                    if (acq_end)
                    begin
                        state_ff <= adc_seq_pkg::CONV_RUN;
                        phase_ff <= 4'h0;
                        start_ff <= 1'b1;
                    end
                adc_seq_pkg::CONV_RUN:
                    if (finish)
                        state_ff <= adc_seq_pkg::CONV_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
            result_ff <= '0;
        else if (finish && act_ff[owner_ff])
            result_ff[slot_ff] <= code; // [R7]
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer pointers, counts, end flags, interrupts
    logic [1:0][3:0] nxt_ptr;
    logic [1:0][3:0] nxt_left;
    logic [1:0] nxt_act;
    logic [1:0] nxt_pend;
    logic [1:0] eos_ev;
    logic [1:0] nxt_eos_cnt;
    logic [1:0] nxt_irq;

    always_comb
    begin
        for (int s = 0; s < 2; s++)
        begin
            nxt_ptr[s] = ptr_ff[s];
            nxt_left[s] = left_ff[s];
            nxt_act[s] = act_ff[s];
            nxt_pend[s] = pend_ff[s];
            nxt_eos_cnt[s] = eos_cnt_ff[s];
            nxt_irq[s] = 1'b0;
            eos_ev[s] = 1'b0;
            if (fin[s] && act_ff[s])
            begin
                nxt_ptr[s] = (ptr_ff[s] == (s == 0 ? lim1 : 4'h7)) ? 4'h0 : ptr_ff[s] + 4'h1;
                nxt_left[s] = left_ff[s] - 4'h1;
                if (left_ff[s] == 4'h0)
                begin
                    eos_ev[s] = 1'b1; // [R20]
                    // Start/stop keeps the pointer so the next trigger continues
                    if (!ctrl_ff.start_stop)
                        nxt_ptr[s] = 4'h0; // [R10]
                    nxt_act[s] = pend_ff[s];
                    nxt_pend[s] = 1'b0;
                    nxt_left[s] = s == 0 ? len1 : len2;
                end
            end
            if (trig[s])
            begin
                if (nxt_act[s])
                    nxt_pend[s] = 1'b1; // [R21]
                else
                begin
                    nxt_act[s] = 1'b1; // [R8]
                    nxt_left[s] = s == 0 ? len1 : len2; // [R3]
                end
            end
            if (eos_ev[s])
            begin
                nxt_eos_cnt[s] = ~eos_cnt_ff[s];
                nxt_irq[s] = ~ctrl_ff.int_other | eos_cnt_ff[s]; // [R9]
            end
            if (sw_reset[s] || (s == 1 && casc))
            begin
                nxt_ptr[s] = 4'h0;
                nxt_act[s] = 1'b0;
                nxt_pend[s] = 1'b0;
                nxt_eos_cnt[s] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            ptr_ff <= '0;
            left_ff <= '0;
            act_ff <= 2'h0;
            pend_ff <= 2'h0;
            eos_cnt_ff <= 2'h0;
            eos_flag_ff <= 2'h0;
            irq_ff <= 2'h0;
            trg_a_q_ff <= 1'b0;
            trg_b_q_ff <= 1'b0;
            trg_x_q_ff <= 1'b0;
        end
        else
        begin
            ptr_ff <= nxt_ptr;
            left_ff <= nxt_left;
            act_ff <= nxt_act;
            pend_ff <= nxt_pend;
            eos_cnt_ff <= nxt_eos_cnt;
            // Set beats a simultaneous clear
            eos_flag_ff <= (eos_flag_ff & ~eos_clr) | eos_ev; // [R20]
            irq_ff <= nxt_irq;
            trg_a_q_ff <= i_start_trigger_a;
            trg_b_q_ff <= i_start_trigger_b;
            trg_x_q_ff <= i_external_interrupt_two_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_converter_clock_enable = ctrl_ff.clk_en;
    assign o_analog_enable = run_ok; // [R15] [R18]
    assign o_sample_hold = in_acq;
    assign o_conv_start = start_ff;
    assign o_mux_channel = mux_ff;
    assign o_irq_seq1 = irq_ff[0];
    assign o_irq_seq2 = irq_ff[1];

endmodule

// ---- sim/adc_autosequencer_control_monitor.sv ----
module adc_seq_monitor (
    input wire logic i_clk_sys, // clock
    input wire logic i_resetn, // reset
    input wire logic i_awvalid, // aw
    input wire logic o_awready, // aw
    input wire logic i_wvalid, // w
    input wire logic o_wready, // w
    input wire logic o_bvalid, // b
    input wire logic i_bready, // b
    input wire logic [1:0] o_bresp, // b
    input wire logic i_arvalid, // ar
    input wire logic o_arready, // ar
    input wire logic o_rvalid, // r
    input wire logic i_rready, // r
    input wire logic [31:0] o_rdata, // r
    input wire logic i_halt, // halt
    input wire logic o_converter_clock_enable, // enable
    input wire logic o_analog_enable, // analog
    input wire logic o_sample_hold, // acquire
    input wire logic o_conv_start, // start
    input wire logic [3:0] o_mux_channel, // channel
    input wire logic o_irq_seq1, // irq
    input wire logic o_irq_seq2 // irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking mc @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////
    analog_power_a: assert property (
        o_analog_enable == (o_converter_clock_enable && !i_halt)) else $error("analog enable wrong");
    reset_off_a: assert property (
        $rose(i_resetn) |-> !o_converter_clock_enable && !o_sample_hold) else $error("active after reset");
    idle_off_a: assert property (
        !o_converter_clock_enable && !$past(o_converter_clock_enable) |-> !o_sample_hold && !o_conv_start)
        else $error("converting while disabled");
    conv_alone_a: assert property (
        o_conv_start |-> !o_sample_hold ##1 !o_conv_start) else $error("overlapping conversion");
    acq_first_a: assert property (
        $rose(o_conv_start) |-> $past(o_sample_hold)) else $error("conversion without acquisition");
    halt_hold_a: assert property (
        i_halt && $past(i_halt) |-> $stable(o_mux_channel) && !o_conv_start) else $error("halt not frozen");
    write_resp_a: assert property (
        i_awvalid && o_awready && i_wvalid && o_wready |=> ##1 o_bvalid) else $error("late write answer");
    bresp_hold_a: assert property (
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
    read_resp_a: assert property (
        i_arvalid && o_arready |=> o_rvalid) else $error("late read answer");
    rdata_hold_a: assert property (
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("read answer dropped");
    irq_pulse_a: assert property (
        o_irq_seq1 || o_irq_seq2 |=> !o_irq_seq1 && !o_irq_seq2) else $error("interrupt not a pulse");
    cover property (o_irq_seq1);
    cover property (o_irq_seq2);
    cover property (i_halt && o_converter_clock_enable);
endmodule

bind adc_autosequencer_control adc_seq_monitor u_mon (.i_clk_sys, .i_resetn, .i_awvalid, .o_awready,
    .i_wvalid, .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .o_rvalid, .i_rready,
    .o_rdata, .i_halt, .o_converter_clock_enable, .o_analog_enable, .o_sample_hold, .o_conv_start,
    .o_mux_channel, .o_irq_seq1, .o_irq_seq2);

// ---- sim/conv_core_model.sv ----
module conv_core_model (
    input wire logic i_clk, // system clock
    input wire logic i_start, // conversion start
    input wire logic i_hold, // acquisition window
    input wire logic [3:0] i_ch, // channel
    output logic [11:0] o_code, // core code
    output logic o_under, // below zero
    output logic o_over // above full scale
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] ch_ff = 4'h0;
    logic live_ff = 1'b0;
    logic [3:0] ch;
    logic live;
    assign live = i_start || live_ff;
    assign ch = i_start ? i_ch : ch_ff;
    // Channel 1 under range, channel 2 over
    assign o_under = live && ch == 4'h1;
    assign o_over = live && ch == 4'h2;
    // Inverted when idle so stale samples never match
    assign o_code = live ? {3{ch}} : ~{3{ch}};
    always @(posedge i_clk)
    begin
        if (i_start)
        begin
            ch_ff <= i_ch;
            live_ff <= 1'b1;
        end
        else if (i_hold)
            live_ff <= 1'b0;
    end
endmodule

// ---- sim/tb_adc_autosequencer_control.sv ----
module tb_adc_autosequencer_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys = 1'b0, i_resetn = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_halt = 1'b0;
    logic i_start_trigger_a = 1'b0, i_start_trigger_b = 1'b0, i_external_interrupt_two_input = 1'b0;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'hF;
    wire logic [11:0] i_conv_code;
    wire logic i_conv_under, i_conv_over;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_converter_clock_enable, o_analog_enable;
    logic o_sample_hold, o_conv_start, o_irq_seq1, o_irq_seq2;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata, d;
    logic [3:0] o_mux_channel;
    logic [1:0] r;
    int mismatches = 0, n_compared = 0, n_irq1 = 0, n_irq2 = 0;
    logic [11:0] exp1 [4] = '{12'h333, 12'h333, 12'h000, 12'hFFF};

    adc_autosequencer_control u_dut (.i_clk_sys, .i_resetn, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
        .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
        .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_start_trigger_a, .i_start_trigger_b,
        .i_external_interrupt_two_input, .i_halt, .i_conv_code, .i_conv_under, .i_conv_over,
        .o_converter_clock_enable, .o_analog_enable, .o_sample_hold, .o_conv_start, .o_mux_channel,
        .o_irq_seq1, .o_irq_seq2);
    conv_core_model u_core (.i_clk(i_clk_sys), .i_start(o_conv_start), .i_hold(o_sample_hold),
        .i_ch(o_mux_channel), .o_code(i_conv_code), .o_under(i_conv_under), .o_over(i_conv_over));

    always #50 i_clk_sys = ~i_clk_sys;
    always @(negedge i_clk_sys)
    begin
        n_irq1 += (o_irq_seq1 === 1'b1);
        n_irq2 += (o_irq_seq2 === 1'b1);
    end
    ////////////////////////////////////////
    task automatic conclude();
        $display("Compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Exhausted bound ends the run
    task automatic tmo(input int n);
        if (n >= 60)
        begin
            chk("wait_bound", 32'h0, 32'h1);
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb = 1'b0;
        @(posedge i_clk_sys);
        {i_awvalid, i_wvalid, i_bready} <= 3'h7;
        i_awaddr <= a;
        i_wdata <= v;
        for (int n = 0; n < 60 && !tb; n++)
        begin
            @(negedge i_clk_sys);
            ta = o_awready === 1'b1;
            tw = o_wready === 1'b1;
            tb = o_bvalid === 1'b1;
            @(posedge i_clk_sys);
            if (ta)
                i_awvalid <= 1'b0;
            if (tw)
                i_wvalid <= 1'b0;
            if (tb)
                i_bready <= 1'b0;
        end
        tmo(tb ? 0 : 60);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, tr = 1'b0;
        @(posedge i_clk_sys);
        {i_arvalid, i_rready} <= 2'h3;
        i_araddr <= a;
        for (int n = 0; n < 60 && !tr; n++)
        begin
            @(negedge i_clk_sys);
            ta = o_arready === 1'b1;
            tr = o_rvalid === 1'b1;
            v = o_rdata;
            rs = o_rresp;
            @(posedge i_clk_sys);
            if (ta)
                i_arvalid <= 1'b0;
            if (tr)
                i_rready <= 1'b0;
        end
        tmo(tr ? 0 : 60);
    endtask
    // Waits until sequencers and converter are idle
    task automatic idle_wait();
        int n = 0;
        logic [31:0] v;
        logic [1:0] rs;
        do
            rd(8'h10, v, rs);
        while ((v & 32'h400F) != 32'h0 && ++n < 60);
        tmo(n);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        rd(8'h00, d, r);
        chk("ctrl_reset", 32'h0, d);
        wr(8'h04, 32'h11);
        rd(8'h04, d, r);
        chk("presc_locked", 32'h0, d);
        wr(8'h00, 32'h1);
        repeat (20) @(posedge i_clk_sys);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h13);
        wr(8'h14, 32'h2133);
        wr(8'h18, 32'h65);
        wr(8'h0C, 32'h1);
        idle_wait();
        for (int i = 0; i < 4; i++)
        begin
            rd(8'h40 + 8'(4 * i), d, r);
            chk("result_seq1", {20'h0, exp1[i]}, d);
        end
        wr(8'h00, 32'h31);
        @(posedge i_clk_sys);
        {i_start_trigger_a, i_start_trigger_b} <= 2'h3;
        repeat (2) @(posedge i_clk_sys);
        {i_start_trigger_a, i_start_trigger_b} <= 2'h0;
        idle_wait();
        rd(8'h60, d, r);
        chk("result_slot8", 32'hDDD, d);
        rd(8'h64, d, r);
        chk("result_slot9", 32'hEEE, d);
        chk("irq_counts", 32'h21, 32'(n_irq1 * 16 + n_irq2));
        rd(8'h10, d, r);
        chk("end_flags", 32'h3000, d & 32'h3000);
        wr(8'h10, 32'h3000);
        rd(8'h10, d, r);
        chk("end_cleared", 32'h0, d & 32'h3003);
        wr(8'h00, 32'h09);
        wr(8'h0C, 32'h1);
        wr(8'h0C, 32'h1);
        idle_wait();
        chk("every_other", 32'h3, 32'(n_irq1));
        wr(8'h00, 32'h05);
        wr(8'h08, 32'h01);
        wr(8'h0C, 32'h10);
        for (int i = 0; i < 2; i++)
        begin
            wr(8'h0C, 32'h1);
            idle_wait();
        end
        rd(8'h10, d, r);
        chk("stop_pointer", 32'h4, (d >> 4) & 32'hF);
        wr(8'h00, 32'h43);
        wr(8'h0C, 32'h10);
        wr(8'h08, 32'h08);
        @(posedge i_clk_sys);
        i_external_interrupt_two_input <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_external_interrupt_two_input <= 1'b0;
        idle_wait();
        rd(8'h60, d, r);
        chk("cascade_slot8", 32'h555, d);
        i_halt <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        chk("halt_analog", 32'h0, {31'h0, o_analog_enable});
        rd(8'h00, d, r);
        chk("halt_ctrl", 32'h43, d);
        i_halt <= 1'b0;
        rd(8'h20, d, r);
        chk("unmapped_resp", 32'h2, {30'h0, r});
        chk("unmapped_data", 32'h0, d);
        conclude();
    end
endmodule
